//--- pkg/epc_pkg.sv
// Constants for the eight-pin port control block
package epc_pkg;
  localparam int unsigned EPC_PINS = 8;
  localparam int unsigned EPC_ADDR_W = 8;
  localparam int unsigned EPC_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] EPC_OFF_DATA = 8'h00;
  localparam logic [7:0] EPC_OFF_OE = 8'h04;
  localparam logic [7:0] EPC_OFF_FS1 = 8'h08;
  localparam logic [7:0] EPC_OFF_FS2 = 8'h0C;
  localparam logic [7:0] EPC_OFF_FS3 = 8'h10;
  localparam logic [7:0] EPC_OFF_FS4 = 8'h14;
  localparam logic [7:0] EPC_OFF_RSV_LO = 8'h18;
  localparam logic [7:0] EPC_OFF_RSV_HI = 8'h24;
  localparam logic [7:0] EPC_OFF_OD = 8'h28;
  localparam logic [7:0] EPC_OFF_PUP = 8'h2C;
  localparam logic [7:0] EPC_OFF_PDN = 8'h30;
  localparam logic [7:0] EPC_OFF_RSV_E = 8'h34;
  localparam logic [7:0] EPC_OFF_IE = 8'h38;
  localparam logic [7:0] EPC_OFF_OPUP = 8'h40;
  localparam logic [7:0] EPC_OFF_OPDN = 8'h44;
  localparam logic [7:0] EPC_OFF_OIE = 8'h48;

  // Writable bit masks
  localparam logic [7:0] EPC_MASK_ALL = 8'hFF;
  localparam logic [7:0] EPC_MASK_FS2 = 8'hFE;
  localparam logic [7:0] EPC_MASK_FS4 = 8'h0C;

  // Reset values
  localparam logic [7:0] EPC_RST_REG = 8'h00;
  localparam logic [31:0] EPC_RST_WORD = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] EPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EPC_RESP_SLVERR = 2'h2;

  // Bus line that pin 0 carries in bus mode
  localparam int unsigned EPC_BUS_LINE_LOW = 8;
endpackage

//--- rtl/epc_top.sv
// Eight-pin port control with AXI4-Lite register access
// Behaviour
// - The data register holds one read/write bit per pin in 7:0, upper bits read zero, reset zero.
// - The output enable register at 0x0004 turns each pin driver on with a one, reset all off.
// - Function select one at 0x0008 routes pin n to bus line 8+n when set, reset zero.
// - Function select two at 0x000C is decoded and selects an alternate function for pins 1 to 7; bit 0 reads zero.
// - Function select three at 0x0010 is decoded per pin; function select four at 0x0014 holds only bits 3:2.
// - The open-drain select register at 0x0028 is decoded.
// - The pull-up register holds one enable per pin, upper bits zero, reset zero.
// - The pull-down register holds one enable per pin, upper bits zero, reset zero.
// - The input enable register enables each pin input path, all disabled after reset.
// - Pull-up sits at 0x002C and pull-down at 0x0030.
// - Input enable sits at 0x0038 and data at 0x0000.
// - An open-drain bit of one gives an open-drain driver, zero push-pull, upper bits zero.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module epc_top
  import epc_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [epc_pkg::EPC_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [epc_pkg::EPC_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [epc_pkg::EPC_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [epc_pkg::EPC_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Pads
  input wire logic [epc_pkg::EPC_PINS-1:0] pin_in,
  output logic [epc_pkg::EPC_PINS-1:0] pin_out,
  output logic [epc_pkg::EPC_PINS-1:0] pin_oe,
  output logic [epc_pkg::EPC_PINS-1:0] pin_pullup,
  output logic [epc_pkg::EPC_PINS-1:0] pin_pulldown,
  output logic [epc_pkg::EPC_PINS-1:0] pin_in_data,
  // External bus lines 8 to 15
  input wire logic [epc_pkg::EPC_PINS-1:0] bus_ad_out,
  input wire logic [epc_pkg::EPC_PINS-1:0] bus_ad_oe,
  output logic [epc_pkg::EPC_PINS-1:0] bus_ad_in,
  // Alternate peripheral functions two to four
  input wire logic [epc_pkg::EPC_PINS-1:0] alt2_out,
  input wire logic [epc_pkg::EPC_PINS-1:0] alt2_oe,
  input wire logic [epc_pkg::EPC_PINS-1:0] alt3_out,
  input wire logic [epc_pkg::EPC_PINS-1:0] alt3_oe,
  input wire logic [epc_pkg::EPC_PINS-1:0] alt4_out,
  input wire logic [epc_pkg::EPC_PINS-1:0] alt4_oe,
  // Function selects seen by peripherals
  output logic [epc_pkg::EPC_PINS-1:0] fs1_sel,
  output logic [epc_pkg::EPC_PINS-1:0] fs2_sel,
  output logic [epc_pkg::EPC_PINS-1:0] fs3_sel,
  output logic [epc_pkg::EPC_PINS-1:0] fs4_sel,
  // Neighbouring port pad controls
  output logic [epc_pkg::EPC_PINS-1:0] other_pullup,
  output logic [epc_pkg::EPC_PINS-1:0] other_pulldown,
  output logic [epc_pkg::EPC_PINS-1:0] other_in_en
);
  import epc_pkg::*;

  // Register file
  logic [7:0] data_q;
  logic [7:0] oe_q;
  logic [7:0] fs1_q;
  logic [7:0] fs2_q;
  logic [7:0] fs3_q;
  logic [7:0] fs4_q;
  logic [7:0] od_q;
  logic [7:0] pup_q;
  logic [7:0] pdn_q;
  logic [7:0] ie_q;
  logic [7:0] opup_q;
  logic [7:0] opdn_q;
  logic [7:0] oie_q;
  logic [7:0] pin_in_q;

  // Write channel state
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] waddr_al;

  // Read channel state
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] raddr_al;
  logic [7:0] rd_val;
  logic rd_hit;

  // Aligned addresses; low two bits ignored
  assign waddr_al = {waddr_q[7:2], 2'b00};
  assign raddr_al = {araddr[7:2], 2'b00};

  // Decode of every implemented register
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      EPC_OFF_DATA, EPC_OFF_OE, EPC_OFF_FS1: hit = 1'b1;
      EPC_OFF_FS2: hit = 1'b1;
      EPC_OFF_FS3, EPC_OFF_FS4: hit = 1'b1;
      EPC_OFF_OD: hit = 1'b1;
      EPC_OFF_PUP, EPC_OFF_PDN: hit = 1'b1;
      EPC_OFF_IE: hit = 1'b1;
      EPC_OFF_OPUP, EPC_OFF_OPDN, EPC_OFF_OIE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Write address and data are accepted in either order
  assign awready = clk_en & ~aw_held_q & ~bvalid_q;
  assign wready = clk_en & ~w_held_q & ~bvalid_q;
  assign wr_fire = clk_en & aw_held_q & w_held_q & ~bvalid_q;
  assign wr_hit = is_mapped(waddr_al);
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= EPC_RST_REG;
      wbyte_q <= EPC_RST_REG;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= EPC_RESP_OKAY;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        // Reserved and unmapped offsets answer with an error
        bresp_q <= wr_hit ? EPC_RESP_OKAY : EPC_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register updates; only byte lane 0 carries stored bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= EPC_RST_REG;
      oe_q <= EPC_RST_REG;
      fs1_q <= EPC_RST_REG;
      fs2_q <= EPC_RST_REG;
      fs3_q <= EPC_RST_REG;
      fs4_q <= EPC_RST_REG;
      od_q <= EPC_RST_REG;
      pup_q <= EPC_RST_REG;
      pdn_q <= EPC_RST_REG;
      ie_q <= EPC_RST_REG;
      opup_q <= EPC_RST_REG;
      opdn_q <= EPC_RST_REG;
      oie_q <= EPC_RST_REG;
    end else if (wr_fire && wlane_q) begin
      unique case (waddr_al)
        EPC_OFF_DATA: data_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_OE: oe_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_FS1: fs1_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_FS2: fs2_q <= wbyte_q & EPC_MASK_FS2;
        EPC_OFF_FS3: fs3_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_FS4: fs4_q <= wbyte_q & EPC_MASK_FS4;
        EPC_OFF_OD: od_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_PUP: pup_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_PDN: pdn_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_IE: ie_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_OPUP: opup_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_OPDN: opdn_q <= wbyte_q & EPC_MASK_ALL;
        EPC_OFF_OIE: oie_q <= wbyte_q & EPC_MASK_ALL;
        default: ;
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_val = EPC_RST_REG;
    rd_hit = 1'b1;
    unique case (raddr_al)
      EPC_OFF_DATA: rd_val = data_q;
      EPC_OFF_OE: rd_val = oe_q;
      EPC_OFF_FS1: rd_val = fs1_q;
      EPC_OFF_FS2: rd_val = fs2_q;
      EPC_OFF_FS3: rd_val = fs3_q;
      EPC_OFF_FS4: rd_val = fs4_q;
      EPC_OFF_OD: rd_val = od_q;
      EPC_OFF_PUP: rd_val = pup_q;
      EPC_OFF_PDN: rd_val = pdn_q;
      EPC_OFF_IE: rd_val = ie_q;
      EPC_OFF_OPUP: rd_val = opup_q;
      EPC_OFF_OPDN: rd_val = opdn_q;
      EPC_OFF_OIE: rd_val = oie_q;
      default: rd_hit = 1'b0;
    endcase
  end

  assign arready = clk_en & ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= EPC_RST_WORD;
      rresp_q <= EPC_RESP_OKAY;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        rvalid_q <= 1'b1;
        // Upper 24 bits always zero
        rdata_q <= {24'h00_0000, rd_val};
        rresp_q <= rd_hit ? EPC_RESP_OKAY : EPC_RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Input path sampled only where enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_in_q <= EPC_RST_REG;
    end else if (clk_en) begin
      pin_in_q <= pin_in & ie_q;
    end
  end

  assign pin_in_data = pin_in_q;
  assign bus_ad_in = pin_in_q & fs1_q;
  assign pin_pullup = pup_q;
  assign pin_pulldown = pdn_q;
  assign fs1_sel = fs1_q;
  assign fs2_sel = fs2_q;
  assign fs3_sel = fs3_q;
  assign fs4_sel = fs4_q;
  assign other_pullup = opup_q;
  assign other_pulldown = opdn_q;
  assign other_in_en = oie_q;

  // Per-pin output mux; bus mode first, then functions two to four
  for (genvar i = 0; i < EPC_PINS; i++) begin : g_pin
    logic drv_val;
    logic drv_en;
    always_comb begin
      if (fs1_q[i]) begin
        drv_val = bus_ad_out[i];
        drv_en = bus_ad_oe[i];
      end else if (fs2_q[i]) begin
        drv_val = alt2_out[i];
        drv_en = alt2_oe[i];
      end else if (fs3_q[i]) begin
        drv_val = alt3_out[i];
        drv_en = alt3_oe[i];
      end else if (fs4_q[i]) begin
        drv_val = alt4_out[i];
        drv_en = alt4_oe[i];
      end else begin
        drv_val = data_q[i];
        drv_en = oe_q[i];
      end
    end
    // Open-drain pulls low only and floats for a one
    assign pin_out[i] = od_q[i] ? 1'b0 : drv_val;
    assign pin_oe[i] = drv_en & (~od_q[i] | ~drv_val);
  end

endmodule // epc_top

//--- verif/epc_top_asserts.sv
// Concurrent checks on the eight-pin port control ports
`timescale 1ns/100ps
module epc_top_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Pad and select outputs
  input wire logic [7:0] pin_in_data,
  input wire logic [7:0] bus_ad_in,
  input wire logic [7:0] fs1_sel,
  input wire logic [7:0] fs2_sel,
  input wire logic [7:0] fs4_sel,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_pulldown
);
  default clocking cb @(posedge aclk);
  endclocking
  rd_answer_a: assert property (disable iff (!aresetn) arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  rd_hold_a: assert property (disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped early");
  wr_answer_a: assert property (disable iff (!aresetn)
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer off time");
  wr_hold_a: assert property (disable iff (!aresetn) bvalid && !bready |=> bvalid)
    else $error("write answer dropped early");
  rd_upper_zero_a: assert property (disable iff (!aresetn) rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  bus_in_route_a: assert property (disable iff (!aresetn) bus_ad_in == (pin_in_data & fs1_sel))
    else $error("bus line input routing wrong");
  freeze_ready_a: assert property (disable iff (!aresetn)
    !clk_en |-> !awready && !wready && !arready) else $error("bus taken while frozen");
  fs2_low_zero_a: assert property (disable iff (!aresetn) fs2_sel[0] == 1'b0)
    else $error("select two bit zero set");
  fs4_bits_a: assert property (disable iff (!aresetn) (fs4_sel & 8'hF3) == 8'h00)
    else $error("select four spare bits set");
  pad_reset_a: assert property (!aresetn |=> pin_oe == 8'h00 && pin_pullup == 8'h00
    && pin_pulldown == 8'h00 && fs1_sel == 8'h00) else $error("pad controls not cleared");
endmodule // epc_top_asserts
bind epc_top epc_top_asserts i_epc_top_asserts (.*);

//--- verif/epc_top_tb.sv
// Self-checking bench for the eight-pin port control block
`timescale 1ns/100ps
module epc_top_tb;
  import epc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pin_in = 8'h00, bus_ad_out = 8'h00;
  logic [7:0] bus_ad_oe = 8'h00, alt2_out = 8'h00, alt2_oe = 8'h00, alt3_out = 8'h00;
  logic [7:0] alt3_oe = 8'h00, alt4_out = 8'h00, alt4_oe = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pin_out, pin_oe, pin_pullup, pin_pulldown, pin_in_data, bus_ad_in;
  logic [7:0] fs1_sel, fs2_sel, fs3_sel, fs4_sel, other_pullup, other_pulldown, other_in_en;
  int errors = 0, samples_checked = 0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [15:0] rnd = 16'hAFFB;
  logic [7:0] wv[0:19];

  epc_top i_epc_top (.*);

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Valid flag and writable mask per offset
  function automatic logic [8:0] mm(input logic [7:0] a);
    case (a)
      8'h0C: return 9'h1FE;
      8'h14: return 9'h10C;
      8'h18, 8'h1C, 8'h20, 8'h24, 8'h34, 8'h3C, 8'h4C: return 9'h000;
      default: return 9'h1FF;
    endcase
  endfunction

  always @(posedge aclk) begin
    rnd <= lfsr(rnd);
    {pin_in, bus_ad_out, bus_ad_oe} <= {rnd, rnd[11:4]};
    {alt2_out, alt3_out, alt4_out, alt2_oe, alt3_oe, alt4_oe} <= {rnd, rnd, rnd};
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge aclk) begin
    if (bvalid && bready) chk(bresp, exp_b.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, exp_r.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    logic done;
    @(posedge aclk);
    exp_b.push_back(er);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'h7;
    done = 1'b0;
    n = 0;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) errors++;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    logic done;
    @(posedge aclk);
    exp_r.push_back(e);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    done = 1'b0;
    n = 0;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) errors++;
  endtask

  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    print_verdict();
  end

  initial begin
    logic [8:0] v;
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] p;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset value, write, read back over the whole map
    for (int a = 0; a < 80; a += 4) begin
      // Reserved offsets 0x18 to 0x24 and 0x34 stay untouched; 0x3C and 0x4C are accessed
      if (a inside {[24:36], 52}) continue;
      v = mm(a[7:0]);
      r = v[8] ? EPC_RESP_OKAY : EPC_RESP_SLVERR;
      rd(a[7:0], {r, 32'h0});
      d = {rnd, rnd};
      wv[a / 4] = d[7:0] & v[7:0];
      wr(a[7:0], d, 4'hF, r);
      rd(a[7:0], {r, 24'h0, wv[a / 4]});
    end
    wr(EPC_OFF_DATA, ~{24'h0, wv[0]}, 4'hE, EPC_RESP_OKAY);
    rd(EPC_OFF_DATA, {EPC_RESP_OKAY, 24'h0, wv[0]});
    @(negedge aclk);
    chk({pin_pullup, pin_pulldown, fs1_sel, fs2_sel}, {wv[11], wv[12], wv[2], wv[3]});
    chk({fs3_sel, fs4_sel, other_pullup, other_pulldown}, {wv[4], wv[5], wv[16], wv[17]});
    chk(other_in_en, wv[18]);
    p = pin_in;
    @(negedge aclk);
    chk(pin_in_data, p & wv[14]);
    // Plain port drive, then open drain, then bus lines
    foreach (wv[i]) if (i inside {2, 3, 4, 5, 10}) wr(8'(i * 4), 32'h0, 4'hF, EPC_RESP_OKAY);
    wr(EPC_OFF_OE, 32'hFF, 4'hF, EPC_RESP_OKAY);
    wr(EPC_OFF_DATA, 32'hA5, 4'hF, EPC_RESP_OKAY);
    @(negedge aclk);
    chk({pin_out, pin_oe}, 16'hA5FF);
    wr(EPC_OFF_OD, 32'hFF, 4'hF, EPC_RESP_OKAY);
    @(negedge aclk);
    chk({pin_out, pin_oe}, 16'h005A);
    wr(EPC_OFF_OD, 32'h0, 4'hF, EPC_RESP_OKAY);
    wr(EPC_OFF_FS1, 32'hFF, 4'hF, EPC_RESP_OKAY);
    @(negedge aclk);
    chk({pin_out, pin_oe}, {bus_ad_out, bus_ad_oe});
    p = pin_in;
    @(negedge aclk);
    chk(bus_ad_in, p & wv[14]);
    // Reset again in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({pin_oe, pin_pullup, fs1_sel}, 24'h0);
    rd(EPC_OFF_DATA, {EPC_RESP_OKAY, 32'h0});
    // Clock enable low freezes sampling and refuses the bus
    wr(EPC_OFF_IE, 32'hFF, 4'hF, EPC_RESP_OKAY);
    @(posedge aclk);
    clk_en <= 1'b0;
    @(negedge aclk);
    p = pin_in_data;
    repeat (4) @(negedge aclk);
    chk({pin_in_data, awready, wready, arready}, {p, 3'b000});
    @(posedge aclk);
    clk_en <= 1'b1;
    repeat (3) @(posedge aclk);
    print_verdict();
  end
endmodule // epc_top_tb
